// ---- verilog/xmi_ext_mem_port.sv ----
// xmi external data memory interface: address generation, ram and off-chip port
`timescale 1ns/1ps
`include "xmi_cfg.svh"
module xmi_ext_mem_port #(
   parameter int STROBE_CYC = `XMI_STROBE_CYC,
   parameter int ALE_CYC    = `XMI_ALE_CYC
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // configuration
   input  wire logic [1:0]        memoryModeField,
   input  wire logic              multiplexSelectBit,
   input  wire logic              flashWriteEn,
   // byte register writes (page select, pointer halves)
   input  wire logic              pageWrEn,
   input  wire xmi_pkg::xmi_byte_t pageWrData,
   input  wire logic              ptrHighWrEn,
   input  wire logic              ptrLowWrEn,
   input  wire xmi_pkg::xmi_byte_t ptrByteData,
   input  wire logic              ptrLoadEn,
   input  wire xmi_pkg::xmi_addr_t ptrLoadData,
   // core access request
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic              reqWide,
   input  wire xmi_pkg::xmi_byte_t reqIndex,
   input  wire xmi_pkg::xmi_byte_t reqWdata,
   // core answer and register readback
   output xmi_pkg::xmi_byte_t     rspData,
   output logic                   rspDone,
   output logic                   busy,
   output xmi_pkg::xmi_byte_t     xramPageSelectReg,
   output xmi_pkg::xmi_byte_t     pointerHighByte,
   output xmi_pkg::xmi_byte_t     pointerLowByte,
   output logic                   flashWriteSel,
   // port pins: data/shared lines (oe low = driving)
   input  wire xmi_pkg::xmi_byte_t dataLineIn,
   output xmi_pkg::xmi_byte_t     dataLineOut,
   output xmi_pkg::xmi_byte_t     dataLineOeN,
   // port pins: low address (non-mux) and upper address
   output xmi_pkg::xmi_byte_t     lowAddrLine,
   output xmi_pkg::xmi_byte_t     lowAddrOeN,
   output xmi_pkg::xmi_byte_t     upperAddrLine,
   output xmi_pkg::xmi_byte_t     upperAddrOeN,
   // port pins: strobes, read/write active low, ale active high
   output logic                   rdStrobeN,
   output logic                   wrStrobeN,
   output logic                   aleStrobe,
   output logic                   ctrlOeN,
   output logic                   pinsClaimed
);
   import xmi_pkg::*;

   xmi_state_e state_q;
   xmi_byte_t  page_q;
   xmi_addr_t  ptr_q;
   xmi_addr_t  addr_q;
   xmi_byte_t  wdat_q;
   logic       write_q;
   logic       wide_q;
   logic       mux_q;
   logic [3:0] cnt_q;
   logic       ramRd_q;

   xmi_ram_if ramBus ();

   xmi_onchip_ram #(.DEPTH(`XMI_RAM_BYTES)) uRam (
      .clk (clk),
      .ram (ramBus)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic isOffChip(input logic [1:0] mode, input xmi_addr_t a);
      case (mode)
         `XMI_MODE_INT:   isOffChip = 1'b0;
         `XMI_MODE_SPLIT,
         `XMI_MODE_BANK:  isOffChip = (a >= 16'(`XMI_RAM_BYTES));
         `XMI_MODE_EXT:   isOffChip = 1'b1;
         default:         isOffChip = 1'b0;
      endcase
   endfunction : isOffChip

   xmi_addr_t effAddr;
   logic      offChip;
   always_comb begin
      if (reqWide) begin
         effAddr = ptr_q;
      end else begin
         effAddr = {page_q, reqIndex};
      end
      offChip = isOffChip(memoryModeField, effAddr);
   end

   // ----------------------------------------------------------------
   // byte registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_q <= `XMI_PAGE_RST;
      end else if (pageWrEn) begin
         page_q <= pageWrData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_q <= `XMI_PTR_RST;
      end else if (ptrLoadEn) begin
         ptr_q <= ptrLoadData;
      end else begin
         if (ptrHighWrEn) begin
            ptr_q[15:8] <= ptrByteData;
         end
         if (ptrLowWrEn) begin
            ptr_q[7:0] <= ptrByteData;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xramPageSelectReg <= `XMI_PAGE_RST;
         pointerHighByte   <= `XMI_PAGE_RST;
         pointerLowByte    <= `XMI_PAGE_RST;
         flashWriteSel     <= 1'b0;
      end else begin
         xramPageSelectReg <= pageWrEn ? pageWrData : page_q;
         pointerHighByte   <= ptrLoadEn ? ptrLoadData[15:8] :
                              (ptrHighWrEn ? ptrByteData : ptr_q[15:8]);
         pointerLowByte    <= ptrLoadEn ? ptrLoadData[7:0] :
                              (ptrLowWrEn ? ptrByteData : ptr_q[7:0]);
         flashWriteSel     <= flashWriteEn;
      end
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   logic takeReq;
   assign takeReq = (state_q == XMI_IDLE) && reqValid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= XMI_IDLE;
         cnt_q   <= 4'h0;
      end else begin
         case (state_q)
            XMI_IDLE: begin
               if (reqValid) begin
                  if (!offChip) begin
                     state_q <= XMI_RAM;
                  end else if (multiplexSelectBit == `XMI_MUX_SHARED) begin
                     state_q <= XMI_ALE;
                     cnt_q   <= 4'(ALE_CYC);
                  end else begin
                     state_q <= XMI_SETUP;
                     cnt_q   <= `XMI_SETUP_CYC;
                  end
               end
            end
            XMI_RAM: state_q <= XMI_DONE;
            XMI_ALE: begin
               if (cnt_q == 4'h1) begin
                  state_q <= XMI_SETUP;
                  cnt_q   <= `XMI_SETUP_CYC;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            XMI_SETUP: begin
               if (cnt_q == 4'h1) begin
                  state_q <= XMI_STROBE;
                  cnt_q   <= 4'(STROBE_CYC);
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            XMI_STROBE: begin
               if (cnt_q == 4'h1) begin
                  state_q <= XMI_DONE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            XMI_DONE: state_q <= XMI_IDLE;
            default:  state_q <= XMI_IDLE;
         endcase
      end
   end

   // request capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q  <= `XMI_PTR_RST;
         wdat_q  <= `XMI_PAGE_RST;
         write_q <= 1'b0;
         wide_q  <= 1'b0;
         mux_q   <= 1'b0;
      end else if (takeReq) begin
         addr_q  <= effAddr;
         wdat_q  <= reqWdata;
         write_q <= reqWrite;
         wide_q  <= reqWide;
         mux_q   <= multiplexSelectBit;
      end
   end

   // on-chip ram port; internal-only mode aliases every address
   assign ramBus.en    = takeReq && !offChip;
   assign ramBus.we    = reqWrite && !flashWriteEn;
   assign ramBus.addr  = effAddr[`XMI_RAM_AW-1:0];
   assign ramBus.wdata = reqWdata;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramRd_q <= 1'b0;
      end else begin
         ramRd_q <= (state_q == XMI_RAM) && !write_q;
      end
   end

   // pin data crosses two flops; only the second one is read by the logic
   xmi_byte_t dataSync1_q;
   xmi_byte_t dataSync2_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataSync1_q <= `XMI_DATA_RST;
         dataSync2_q <= `XMI_DATA_RST;
      end else begin
         dataSync1_q <= dataLineIn;
         dataSync2_q <= dataSync1_q;
      end
   end

   // ----------------------------------------------------------------
   // answer to the core
   // ----------------------------------------------------------------
   logic sampleExt;
   assign sampleExt = (state_q == XMI_STROBE) && (cnt_q == 4'h1) && !write_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rspData <= `XMI_PAGE_RST;
         rspDone <= 1'b0;
         busy    <= 1'b0;
      end else begin
         rspDone <= (state_q == XMI_DONE);
         busy    <= (state_q != XMI_IDLE) || reqValid;
         if (sampleExt) begin
            rspData <= dataSync2_q;
         end else if (ramRd_q) begin
            rspData <= ramBus.rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin control
   // ----------------------------------------------------------------
   logic claim;
   logic strobePh;
   logic upperOn;
   assign claim    = (state_q == XMI_ALE) || (state_q == XMI_SETUP)
                     || (state_q == XMI_STROBE);
   assign strobePh = (state_q == XMI_STROBE);
   // 8-bit form in split mode leaves the upper lines to the port latches
   assign upperOn  = claim && (wide_q || (memoryModeField != `XMI_MODE_SPLIT));

   // output mode (open-drain/push-pull) is outside this block entirely
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinsClaimed   <= 1'b0;
         ctrlOeN       <= 1'b1;
         rdStrobeN     <= 1'b1;
         wrStrobeN     <= 1'b1;
         aleStrobe     <= 1'b0;
         dataLineOut   <= 8'hFF;
         dataLineOeN   <= 8'hFF;
         lowAddrLine   <= 8'hFF;
         lowAddrOeN    <= 8'hFF;
         upperAddrLine <= 8'hFF;
         upperAddrOeN  <= 8'hFF;
      end else begin
         pinsClaimed   <= claim;
         ctrlOeN       <= !claim;
         aleStrobe     <= (state_q == XMI_ALE);
         rdStrobeN     <= !(strobePh && !write_q);
         wrStrobeN     <= !(strobePh && write_q);
         upperAddrLine <= addr_q[15:8];
         upperAddrOeN  <= {8{!upperOn}};
         lowAddrLine   <= addr_q[7:0];
         lowAddrOeN    <= {8{!(claim && mux_q)}};
         if (claim && !mux_q && (state_q == XMI_ALE)) begin
            dataLineOut <= addr_q[7:0];
            dataLineOeN <= 8'h00;
         end else begin
            dataLineOut <= wdat_q;
            dataLineOeN <= {8{!(claim && write_q)}};
         end
      end
   end
endmodule : xmi_ext_mem_port

// ---- verilog/xmi_cfg.svh ----
// xmi constants: field positions, reset values and timing counts
`ifndef XMI_CFG_SVH
`define XMI_CFG_SVH
`define XMI_ADDR_W        16
`define XMI_RAM_BYTES     8192
`define XMI_RAM_AW        13
`define XMI_MODE_INT      2'h0
`define XMI_MODE_SPLIT    2'h1
`define XMI_MODE_BANK     2'h2
`define XMI_MODE_EXT      2'h3
`define XMI_MUX_SHARED    1'h0
`define XMI_MUX_SEPARATE  1'h1
`define XMI_PAGE_RST      8'h00
`define XMI_PTR_RST       16'h0000
// a read strobe shorter than four cycles lets the two-flop pin delay miss the data
`define XMI_STROBE_CYC    4'h4
`define XMI_DATA_RST      8'h00
`define XMI_ALE_CYC       4'h1
`define XMI_SETUP_CYC     4'h1
`endif

// ---- verilog/xmi_pkg.sv ----
// xmi package: shared types
package xmi_pkg;
   typedef logic [15:0] xmi_addr_t;
   typedef logic [7:0]  xmi_byte_t;
   typedef enum logic [5:0] {
      XMI_IDLE   = 6'b000001,
      XMI_RAM    = 6'b000010,
      XMI_ALE    = 6'b000100,
      XMI_SETUP  = 6'b001000,
      XMI_STROBE = 6'b010000,
      XMI_DONE   = 6'b100000
   } xmi_state_e;
endpackage : xmi_pkg

// ---- verilog/xmi_ram_if.sv ----
// xmi interface between the controller and its on-chip data ram
`timescale 1ns/1ps
interface xmi_ram_if;
   logic        en;
   logic        we;
   logic [12:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : xmi_ram_if

// ---- verilog/xmi_onchip_ram.sv ----
// xmi on-chip data ram, registered read data
`timescale 1ns/1ps
module xmi_onchip_ram #(
   parameter int DEPTH = 8192
) (
   // clock
   input wire logic clk,
   // port
   xmi_ram_if.mem   ram
);
   logic [7:0] memArr [DEPTH];
   logic [7:0] rdata_q;

   always_ff @(posedge clk) begin
      if (ram.en && ram.we) begin
         memArr[ram.addr] <= ram.wdata;
      end
      if (ram.en) begin
         rdata_q <= memArr[ram.addr];
      end
   end

   assign ram.rdata = rdata_q;
endmodule : xmi_onchip_ram

// ---- tb/xmi_ext_mem_monitor.sv ----
// xmi checker: port-level assertions for the external memory port
`timescale 1ns/1ps
module xmi_ext_mem_monitor #(
   parameter int STROBE_CYC = 4,
   parameter int ALE_CYC    = 1
) (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // core side
   input wire logic [1:0]         memoryModeField,
   input wire logic               reqValid,
   input wire logic               busy,
   input wire logic               rspDone,
   input wire logic               ptrLoadEn,
   input wire xmi_pkg::xmi_addr_t ptrLoadData,
   input wire xmi_pkg::xmi_byte_t pointerHighByte,
   input wire xmi_pkg::xmi_byte_t pointerLowByte,
   // pin side
   input wire xmi_pkg::xmi_byte_t dataLineOut,
   input wire xmi_pkg::xmi_byte_t dataLineOeN,
   input wire xmi_pkg::xmi_byte_t lowAddrOeN,
   input wire xmi_pkg::xmi_byte_t upperAddrOeN,
   input wire logic               rdStrobeN,
   input wire logic               wrStrobeN,
   input wire logic               aleStrobe,
   input wire logic               ctrlOeN,
   input wire logic               pinsClaimed
);
   import xmi_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // pin ownership, strobes, answer timing and pointer load
   // ----------------------------------------
   a_one_strobe: assert property (!(!rdStrobeN && !wrStrobeN))
      else $error("read and write strobes low together");
   a_claim_ctrl: assert property (ctrlOeN == !pinsClaimed)
      else $error("control enable disagrees with claim");
   a_release_idle: assert property (!pinsClaimed |-> dataLineOeN == 8'hFF &&
      lowAddrOeN == 8'hFF && upperAddrOeN == 8'hFF && rdStrobeN && wrStrobeN)
      else $error("pins driven while released");
   a_read_undriven: assert property (!rdStrobeN |-> dataLineOeN == 8'hFF)
      else $error("data lines driven during read");
   a_write_held: assert property (!wrStrobeN && $past(!wrStrobeN) |->
      $stable(dataLineOut) && dataLineOeN == 8'h00)
      else $error("write data not held under strobe");
   a_ale_pulse: assert property (aleStrobe |-> dataLineOeN == 8'h00 && pinsClaimed
      && rdStrobeN && wrStrobeN ##1 !aleStrobe && rdStrobeN && wrStrobeN)
      else $error("address latch pulse malformed");
   a_take_answer: assert property (reqValid && !busy |-> ##[3:8] rspDone)
      else $error("request not answered in time");
   a_onchip_quiet: assert property (reqValid && !busy && memoryModeField == 2'h0
      |-> !pinsClaimed [*6])
      else $error("pins claimed in internal mode");
   a_ext_claims: assert property (reqValid && !busy && memoryModeField == 2'h3
      |-> ##[1:3] pinsClaimed)
      else $error("external mode did not claim pins");
   a_ptr_load: assert property (ptrLoadEn |=>
      {pointerHighByte, pointerLowByte} == $past(ptrLoadData))
      else $error("pointer halves disagree with load");
   c_ale: cover property (aleStrobe);
   c_write: cover property (!wrStrobeN);
   c_read: cover property (!rdStrobeN);
endmodule : xmi_ext_mem_monitor
bind xmi_ext_mem_port xmi_ext_mem_monitor #(.STROBE_CYC(STROBE_CYC), .ALE_CYC(ALE_CYC)) u_mon (
   .clk(clk), .rst(rst), .memoryModeField(memoryModeField), .reqValid(reqValid),
   .busy(busy), .rspDone(rspDone), .ptrLoadEn(ptrLoadEn), .ptrLoadData(ptrLoadData),
   .pointerHighByte(pointerHighByte), .pointerLowByte(pointerLowByte),
   .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN), .lowAddrOeN(lowAddrOeN),
   .upperAddrOeN(upperAddrOeN), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN),
   .aleStrobe(aleStrobe), .ctrlOeN(ctrlOeN), .pinsClaimed(pinsClaimed));

// ---- tb/xmi_far_mem.sv ----
// xmi far-side model: asynchronous byte memory on the port pins
`timescale 1ns/1ps
module xmi_far_mem (
   // clock and bus form
   input wire logic               clk,
   input wire logic               separateBus,
   // pins from the port
   input wire xmi_pkg::xmi_byte_t dataLineOut,
   input wire xmi_pkg::xmi_byte_t lowAddrLine,
   input wire xmi_pkg::xmi_byte_t upperAddrLine,
   input wire xmi_pkg::xmi_byte_t upperAddrOeN,
   input wire logic               rdStrobeN,
   input wire logic               wrStrobeN,
   input wire logic               aleStrobe,
   // data back to the port, address probe
   output xmi_pkg::xmi_byte_t     dataLineIn,
   output xmi_pkg::xmi_addr_t     lastAddr
);
   import xmi_pkg::*;
   xmi_byte_t mem [0:65535];
   xmi_byte_t latchedLow;
   xmi_byte_t lastRd;
   xmi_addr_t curAddr;
   // undriven upper lines sit at the parked high latch level
   assign curAddr = {(upperAddrOeN == 8'h00) ? upperAddrLine : 8'hFF,
                     separateBus ? lowAddrLine : latchedLow};
   // off the strobe the lines show a stale inverse, so late sampling is caught
   assign dataLineIn = rdStrobeN ? ~lastRd : mem[curAddr];
   always @(posedge clk) begin
      if (aleStrobe) latchedLow <= dataLineOut;
      if (!wrStrobeN) mem[curAddr] <= dataLineOut;
      if (!rdStrobeN) lastRd <= mem[curAddr];
      if (!wrStrobeN || !rdStrobeN) lastAddr <= curAddr;
   end
endmodule : xmi_far_mem

// ---- tb/tb_top.sv ----
// xmi testbench: random and corner accesses through the external memory port
`timescale 1ns/1ps
module tb_top;
   import xmi_pkg::*;
   logic clk, rst, mux, flashEn, pageWr, ptrHiWr, ptrLoWr, ptrLoad, reqValid, reqWrite, reqWide;
   logic rspDone, busy, flashSel, rdN, wrN, ale, ctrlOeN, claimed, sawClaim, sawUpper;
   logic [1:0] mode;
   xmi_byte_t pageD, ptrB, idx, wd, din, rspData, pageQ, ptrH, ptrL, dOut, dOeN;
   xmi_byte_t lowA, lowOeN, upA, upOeN;
   xmi_addr_t ptrD, farAddr;
   int mismatches, samples_checked;
   logic [31:0] r;
   xmi_ext_mem_port dut (.clk(clk), .rst(rst), .memoryModeField(mode),
      .multiplexSelectBit(mux), .flashWriteEn(flashEn), .pageWrEn(pageWr), .pageWrData(pageD),
      .ptrHighWrEn(ptrHiWr), .ptrLowWrEn(ptrLoWr), .ptrByteData(ptrB), .ptrLoadEn(ptrLoad),
      .ptrLoadData(ptrD), .reqValid(reqValid), .reqWrite(reqWrite), .reqWide(reqWide),
      .reqIndex(idx), .reqWdata(wd), .rspData(rspData), .rspDone(rspDone), .busy(busy),
      .xramPageSelectReg(pageQ), .pointerHighByte(ptrH), .pointerLowByte(ptrL),
      .flashWriteSel(flashSel), .dataLineIn(din), .dataLineOut(dOut), .dataLineOeN(dOeN),
      .lowAddrLine(lowA), .lowAddrOeN(lowOeN), .upperAddrLine(upA), .upperAddrOeN(upOeN),
      .rdStrobeN(rdN), .wrStrobeN(wrN), .aleStrobe(ale), .ctrlOeN(ctrlOeN),
      .pinsClaimed(claimed));
   xmi_far_mem far (.clk(clk), .separateBus(mux), .dataLineOut(dOut), .lowAddrLine(lowA),
      .upperAddrLine(upA), .upperAddrOeN(upOeN), .rdStrobeN(rdN), .wrStrobeN(wrN),
      .aleStrobe(ale), .dataLineIn(din), .lastAddr(farAddr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (claimed === 1'b1) sawClaim = 1'b1;
      if (upOeN === 8'h00) sawUpper = 1'b1;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("mismatches %0d of %0d checks", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic access(input logic w, input logic wide, input xmi_byte_t i, input xmi_byte_t d);
      int n;
      @(posedge clk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqWide <= wide;
      idx <= i;
      wd <= d;
      sawClaim = 1'b0;
      sawUpper = 1'b0;
      @(posedge clk);
      reqValid <= 1'b0;
      #1;
      for (n = 0; n < 20 && rspDone !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 20) mismatches++;
   endtask : access
   task automatic setAddr(input logic wide, input xmi_addr_t a);
      @(posedge clk);
      ptrLoad <= wide;
      ptrD <= a;
      pageWr <= !wide;
      pageD <= a[15:8];
      @(posedge clk);
      ptrLoad <= 1'b0;
      pageWr <= 1'b0;
   endtask : setAddr
   function automatic logic offchip(input logic [1:0] m, input xmi_addr_t a);
      return m == 2'h3 || (m != 2'h0 && a >= 16'h2000);
   endfunction : offchip
   task automatic run(input logic [1:0] m, input logic x, input logic wide, input xmi_addr_t a,
                      input xmi_byte_t d);
      logic off;
      off = offchip(m, a);
      mode <= m;
      mux <= x;
      setAddr(wide, a);
      access(1'b1, wide, a[7:0], d);
      check(16'(sawClaim), 16'(off));
      check(16'(sawUpper), 16'(off && (wide || m != 2'h1)));
      if (!wide) check(16'(pageQ), 16'(a[15:8]));
      if (off) check(farAddr, (wide || m != 2'h1) ? a : {8'hFF, a[7:0]});
      access(1'b0, wide, a[7:0], 8'h00);
      check(16'(rspData), 16'(d));
      check(16'(sawClaim), 16'(off));
   endtask : run
   initial begin
      {rst, mux, flashEn, pageWr, ptrHiWr, ptrLoWr, ptrLoad, reqValid, reqWrite, reqWide} = 10'h200;
      {mode, pageD, ptrB, idx, wd, ptrD} = 50'h0;
      mismatches = 0;
      samples_checked = 0;
      r = $urandom(32'h4F5F);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({ptrH, ptrL}, 16'h0000);
      check(16'(pageQ), 16'h0000);
      check(16'({flashSel, rdN, wrN, claimed, dOeN}), 16'h06FF);
      for (int k = 0; k < 8; k++) begin
         run(k[2:1], k[0], 1'b1, 16'h1FFF, 8'hA5);
         run(k[2:1], k[0], 1'b1, 16'h2000, 8'h3C);
         run(k[2:1], k[0], 1'b0, 16'hC3E7, 8'h81);
      end
      run(2'h0, 1'b0, 1'b1, 16'hE123, 8'h5A);
      setAddr(1'b1, 16'h0123);
      access(1'b0, 1'b1, 8'h23, 8'h00);
      check(16'(rspData), 16'h005A);
      flashEn <= 1'b1;
      access(1'b1, 1'b1, 8'h23, 8'h77);
      check(16'(flashSel), 16'h0001);
      flashEn <= 1'b0;
      access(1'b0, 1'b1, 8'h23, 8'h00);
      check(16'(rspData), 16'h005A);
      @(posedge clk);
      ptrHiWr <= 1'b1;
      ptrB <= 8'h9B;
      @(posedge clk);
      ptrHiWr <= 1'b0;
      ptrLoWr <= 1'b1;
      ptrB <= 8'h46;
      @(posedge clk);
      ptrLoWr <= 1'b0;
      @(posedge clk);
      #1;
      check({ptrH, ptrL}, 16'h9B46);
      repeat (60) begin
         r = $urandom;
         run(r[1:0], r[2], r[3], r[31:16], r[11:4]);
      end
      stop_test();
   end
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
endmodule : tb_top
